// [inc/digs_pkg.sv]
// Constants and types for the dual image gate sequencer
// Assumes a 100 MHz acquisition clock
package digs_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ        = 100000000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int RATE_MIN_HZ   = 2;
	localparam int RATE_MAX_HZ   = 1000000;
	localparam int RATE_W        = 20;
	localparam int CNT_W         = 32;
	localparam int FRAME_W       = 16;
	// Shortest pair spacing and gate width supported, as ns/ps times and cycle counts
	localparam int PAIR_SPACE_NS  = 450;
	localparam int PAIR_SPACE_CYC = PAIR_SPACE_NS / CLK_PERIOD_NS;
	localparam int GATE_MIN_PS    = 2500;
	localparam int GATE_MIN_CYC   = 1;
	// ----------------------------------------
	// Modes and states
	// ----------------------------------------
	localparam logic MODE_ONE_TRIG = 1'b0;
	localparam logic MODE_PER_SHOT = 1'b1;
	localparam logic SRC_INTERNAL  = 1'b0;
	localparam logic SRC_EXTERNAL  = 1'b1;

	typedef enum logic [7:0] {
		ST_IDLE  = 8'h01,
		ST_WTRIG = 8'h02,
		ST_DELAY = 8'h04,
		ST_GATE  = 8'h08,
		ST_GLOW  = 8'h10,
		ST_SHIFT = 8'h20,
		ST_READ  = 8'h40,
		ST_DONE  = 8'h80
	} digs_state_t;
endpackage

// [inc/digs_trig_if.sv]
// Trigger path between the rate generator/selector and the sequencer
// Assumes one clock domain
`timescale 1ns/1ns
interface digs_trig_if;
	logic trig;
	logic sync_a;
	logic sync_b;
	modport gen (output trig, output sync_a, output sync_b);
	modport seq (input trig, input sync_a, input sync_b);
endinterface

// [design/digs_trig_gen.sv]
// Trigger source: internal rate generator and external edge detect
// Assumes external trigger already passed the comparator and coupling stage
`timescale 1ns/1ns
module digs_trig_gen (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        src_sel,
	input  wire logic                        ext_pol,
	input  wire logic [digs_pkg::RATE_W-1:0] rate_hz,
	input  wire logic                        ext_in,
	digs_trig_if.gen                         tif
);
	logic                        ext_s1_q, ext_s2_q, ext_s3_q;
	logic [digs_pkg::CNT_W-1:0]  acc_q, acc_d;
	logic [digs_pkg::RATE_W-1:0] rate_c;
	logic                        tick_q, tick_d;
	logic                        trig_q, trig_d;
	logic                        ext_edge;

	// ----------------------------------------
	// Rate generator
	// ----------------------------------------
	always_comb begin
		rate_c = rate_hz;
		if (rate_hz < digs_pkg::RATE_W'(digs_pkg::RATE_MIN_HZ)) begin
			rate_c = digs_pkg::RATE_W'(digs_pkg::RATE_MIN_HZ);
		end else if (rate_hz > digs_pkg::RATE_W'(digs_pkg::RATE_MAX_HZ)) begin
			rate_c = digs_pkg::RATE_W'(digs_pkg::RATE_MAX_HZ);
		end
		tick_d = 1'b0;
		acc_d  = acc_q + digs_pkg::CNT_W'(rate_c);
		if (acc_d >= digs_pkg::CNT_W'(digs_pkg::CLK_HZ)) begin
			acc_d  = acc_d - digs_pkg::CNT_W'(digs_pkg::CLK_HZ);
			tick_d = 1'b1;
		end
		ext_edge = (ext_pol == 1'b0) ? (ext_s2_q & ~ext_s3_q) : (~ext_s2_q & ext_s3_q);
		trig_d   = (src_sel == digs_pkg::SRC_INTERNAL) ? tick_q : ext_edge;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_q    <= '0;
			tick_q   <= 1'b0;
			trig_q   <= 1'b0;
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end else begin
			acc_q    <= acc_d;
			tick_q   <= tick_d;
			trig_q   <= trig_d;
			ext_s1_q <= ext_in;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	assign tif.trig   = trig_q;
	assign tif.sync_a = tick_q;
	assign tif.sync_b = tick_q;

	rate_tick_a: assert property (@(posedge clk) disable iff (rst) tick_q |=> !tick_q)
		else $error("Rate tick longer than one cycle");
	src_ext_a: assert property (@(posedge clk) disable iff (rst)
		(src_sel == digs_pkg::SRC_EXTERNAL && $stable(src_sel) && !ext_edge) |=> !trig_q)
		else $error("Trigger from unselected source");
endmodule

// [design/digs_seq.sv]
// Dual image gate sequencer top: gating, afterglow wait, shift and readout
// Assumes configuration ports are static during an acquisition
`timescale 1ns/1ns
module digs_seq #(
	parameter int DLY_W = 24
) (
	input  wire logic                         CLK_SYS,
	input  wire logic                         RESET,
	input  wire logic                         START,
	input  wire logic                         ABORT,
	input  wire logic                         TRIG_MODE,
	input  wire logic                         TRIG_SRC,
	input  wire logic                         TRIG_POL,
	input  wire logic [digs_pkg::RATE_W-1:0]  RATE_HZ,
	input  wire logic [DLY_W-1:0]             DELAY1_CYC,
	input  wire logic [DLY_W-1:0]             DELAY2_CYC,
	input  wire logic [DLY_W-1:0]             GATE1_CYC,
	input  wire logic [DLY_W-1:0]             GATE2_CYC,
	input  wire logic [DLY_W-1:0]             GLOW_CYC,
	input  wire logic [DLY_W-1:0]             READ_CYC,
	input  wire logic [digs_pkg::FRAME_W-1:0] FRAME_COUNT,
	input  wire logic                         EXT_TRIG,
	output logic                              GATE,
	output logic                              XFER,
	output logic                              READOUT,
	output logic                              BUSY,
	output logic                              DONE,
	output logic                              SYNC_A,
	output logic                              SYNC_B,
	output logic [digs_pkg::FRAME_W-1:0]      FRAMES_DONE
);
	digs_trig_if tif ();

	// State codes from the package
	typedef digs_pkg::digs_state_t digs_state_t;
	localparam digs_state_t ST_IDLE  = digs_pkg::ST_IDLE;
	localparam digs_state_t ST_WTRIG = digs_pkg::ST_WTRIG;
	localparam digs_state_t ST_DELAY = digs_pkg::ST_DELAY;
	localparam digs_state_t ST_GATE  = digs_pkg::ST_GATE;
	localparam digs_state_t ST_GLOW  = digs_pkg::ST_GLOW;
	localparam digs_state_t ST_SHIFT = digs_pkg::ST_SHIFT;
	localparam digs_state_t ST_READ  = digs_pkg::ST_READ;
	localparam digs_state_t ST_DONE  = digs_pkg::ST_DONE;

	digs_state_t                    st_q, st_d;
	logic                           busy_q, busy_d;
	logic [DLY_W-1:0]               cnt_q, cnt_d;
	logic                           shot_q, shot_d;
	logic [digs_pkg::FRAME_W-1:0]   frm_q, frm_d;
	logic                           gate_q, gate_d;
	logic                           xfer_q, xfer_d;
	logic                           rd_q, rd_d;
	logic                           done_q, done_d;
	logic                           sa_q, sb_q;
	logic                           stored_q, stored_d;

	digs_trig_gen u_gen (
		.clk     (CLK_SYS),
		.rst     (RESET),
		.src_sel (TRIG_SRC),
		.ext_pol (TRIG_POL),
		.rate_hz (RATE_HZ),
		.ext_in  (EXT_TRIG),
		.tif     (tif)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		st_d     = st_q;
		cnt_d    = cnt_q;
		shot_d   = shot_q;
		frm_d    = frm_q;
		stored_d = stored_q;
		gate_d   = 1'b0;
		xfer_d   = 1'b0;
		rd_d     = 1'b0;
		done_d   = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (START) begin
					frm_d    = '0;
					shot_d   = 1'b0;
					stored_d = 1'b0;
					st_d     = ST_WTRIG;
				end
			end
			ST_WTRIG: begin
				if (tif.trig) begin
					cnt_d = shot_q ? DELAY2_CYC : DELAY1_CYC;
					st_d  = ST_DELAY;
				end
			end
			ST_DELAY: begin
				if (cnt_q == '0) begin
					cnt_d  = (shot_q ? GATE2_CYC : GATE1_CYC) - DLY_W'(1);
					gate_d = 1'b1;
					st_d   = ST_GATE;
				end else begin
					cnt_d = cnt_q - DLY_W'(1);
				end
			end
			ST_GATE: begin
				if (cnt_q == '0) begin
					cnt_d = GLOW_CYC;
					st_d  = ST_GLOW;
				end else begin
					gate_d = 1'b1;
					cnt_d  = cnt_q - DLY_W'(1);
				end
			end
			ST_GLOW: begin
				if (cnt_q == '0) begin
					if (!shot_q) begin
						xfer_d   = 1'b1;
						stored_d = 1'b1;
						st_d     = ST_SHIFT;
					end else begin
						cnt_d = READ_CYC;
						st_d  = ST_READ;
					end
				end else begin
					cnt_d = cnt_q - DLY_W'(1);
				end
			end
			ST_SHIFT: begin
				shot_d = 1'b1;
				if (TRIG_MODE == digs_pkg::MODE_PER_SHOT) begin
					st_d = ST_WTRIG;
				end else begin
					cnt_d = DELAY2_CYC;
					st_d  = ST_DELAY;
				end
			end
			ST_READ: begin
				rd_d = 1'b1;
				if (cnt_q == '0) begin
					rd_d     = 1'b0;
					stored_d = 1'b0;
					frm_d    = frm_q + digs_pkg::FRAME_W'(2);
					st_d     = ST_DONE;
				end else begin
					cnt_d = cnt_q - DLY_W'(1);
				end
			end
			ST_DONE: begin
				shot_d = 1'b0;
				if (frm_q >= FRAME_COUNT) begin
					done_d = 1'b1;
					st_d   = ST_IDLE;
				end else begin
					st_d = ST_WTRIG;
				end
			end
			default: st_d = ST_IDLE;
		endcase
		if (ABORT) begin
			st_d   = ST_IDLE;
			gate_d = 1'b0;
			rd_d   = 1'b0;
			xfer_d = 1'b0;
		end
		busy_d = (st_d != ST_IDLE);
	end

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			st_q     <= ST_IDLE;
			cnt_q    <= '0;
			shot_q   <= 1'b0;
			frm_q    <= '0;
			stored_q <= 1'b0;
			gate_q   <= 1'b0;
			xfer_q   <= 1'b0;
			rd_q     <= 1'b0;
			done_q   <= 1'b0;
			sa_q     <= 1'b0;
			sb_q     <= 1'b0;
			busy_q   <= 1'b0;
		end else begin
			st_q     <= st_d;
			cnt_q    <= cnt_d;
			shot_q   <= shot_d;
			frm_q    <= frm_d;
			stored_q <= stored_d;
			gate_q   <= gate_d;
			xfer_q   <= xfer_d;
			rd_q     <= rd_d;
			done_q   <= done_d;
			sa_q     <= tif.sync_a;
			sb_q     <= tif.sync_b;
			busy_q   <= busy_d;
		end
	end

	assign GATE        = gate_q;
	assign XFER        = xfer_q;
	assign READOUT     = rd_q;
	assign BUSY        = busy_q;
	assign DONE        = done_q;
	assign SYNC_A      = sa_q;
	assign SYNC_B      = sb_q;
	assign FRAMES_DONE = frm_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	one_trig_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(st_q == ST_SHIFT && TRIG_MODE == digs_pkg::MODE_ONE_TRIG && !ABORT) |=> st_q == ST_DELAY)
		else $error("One-trigger pair did not start second exposure");
	per_shot_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(st_q == ST_SHIFT && TRIG_MODE == digs_pkg::MODE_PER_SHOT && !ABORT) |=> st_q == ST_WTRIG)
		else $error("Per-shot mode did not wait for trigger");
	trig_start_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(st_q == ST_WTRIG && !tif.trig && !ABORT) |=> st_q == ST_WTRIG)
		else $error("Exposure started without trigger");
	glow_wait_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(st_q == ST_GATE && cnt_q == '0 && GLOW_CYC != '0 && !ABORT) |=> !XFER ##1 !XFER)
		else $error("Shift before afterglow wait");
	shift_hold_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		$rose(XFER) |=> stored_q)
		else $error("First image not held in storage");
	read_after_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		READOUT |-> shot_q)
		else $error("Readout before second exposure");
	gate_min_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(st_q == ST_DELAY && cnt_q == '0 && !ABORT) |=> GATE)
		else $error("Gate pulse missing");
	pair_loop_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(st_q == ST_DONE && frm_q < FRAME_COUNT && !ABORT) |=> st_q == ST_WTRIG)
		else $error("Sequencer did not rearm");
	ignore_trig_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(st_q == ST_GATE && tif.trig && cnt_q != '0 && !ABORT) |=> st_q == ST_GATE)
		else $error("Trigger disturbed running pair");
	sync_pair_a: assert property (@(posedge CLK_SYS) disable iff (RESET) SYNC_A == SYNC_B)
		else $error("Sync outputs differ");
endmodule

// [tb/digs_ext_src.sv]
// External trigger source model for the sequencer bench
// Assumes the bench clock; changes its line 1 ns after a rising edge
`timescale 1ns/1ns
module digs_ext_src (
	input  wire logic clk,
	output logic      ext_trig
);
	initial ext_trig = 1'b0;

	// Drive the trigger line to a level
	task automatic drive(input logic v);
		@(posedge clk);
		#1 ext_trig = v;
	endtask

	// One pulse whose leading edge is the active edge for pol
	task automatic fire(input logic pol, input int width);
		drive(~pol);
		repeat (width) @(posedge clk);
		#1 ext_trig = pol;
	endtask
endmodule

// [tb/digs_seq_bench.sv]
// Self-checking bench for the dual image gate sequencer
// Assumes the trigger source model in digs_ext_src
`timescale 1ns/1ns
module digs_seq_bench;
	logic                         clk_sys, reset, start, abort, trig_mode, trig_src, trig_pol, ext_trig;
	logic [digs_pkg::RATE_W-1:0]  rate_hz;
	logic [23:0]                  dly1, dly2, gate_w, glow, rd;
	logic [digs_pkg::FRAME_W-1:0] frames, frames_done;
	logic                         gate, xfer, readout, busy, done, sync_a, sync_b, gate_p, read_p;
	int                           error_cnt, tests_run, cyc, n_gate, n_xfer, n_read, n_done;
	int                           t_fall, span, span1, t_sync, period, sync_diff, t_rise, gap, g_width;

	digs_seq dut (.CLK_SYS(clk_sys), .RESET(reset), .START(start), .ABORT(abort), .TRIG_MODE(trig_mode),
		.TRIG_SRC(trig_src), .TRIG_POL(trig_pol), .RATE_HZ(rate_hz), .DELAY1_CYC(dly1), .DELAY2_CYC(dly2),
		.GATE1_CYC(gate_w), .GATE2_CYC(gate_w), .GLOW_CYC(glow), .READ_CYC(rd), .FRAME_COUNT(frames),
		.EXT_TRIG(ext_trig), .GATE(gate), .XFER(xfer), .READOUT(readout), .BUSY(busy), .DONE(done),
		.SYNC_A(sync_a), .SYNC_B(sync_b), .FRAMES_DONE(frames_done));
	digs_ext_src src (.clk(clk_sys), .ext_trig(ext_trig));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// ----------------------------------------
	// Output monitor
	// ----------------------------------------
	always @(posedge clk_sys) begin
		cyc++;
		if (gate === 1'b1 && gate_p === 1'b0) begin
			n_gate++;
			gap    = cyc - t_rise;
			t_rise = cyc;
		end
		if (gate === 1'b0 && gate_p === 1'b1) begin
			t_fall  = cyc;
			g_width = cyc - t_rise;
		end
		if (xfer === 1'b1) begin
			n_xfer++;
			span = cyc - t_fall;
		end
		if (readout === 1'b1 && read_p === 1'b0) n_read++;
		if (done === 1'b1) n_done++;
		if (sync_a === 1'b1) begin
			period = cyc - t_sync;
			t_sync = cyc;
		end
		if (sync_a !== sync_b) sync_diff++;
		gate_p = gate;
		read_p = readout;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %0d seen %0d", name, exp, got);
		end
	endtask

	task automatic go(input logic m, input logic s, input logic [15:0] fr);
		n_gate = 0;
		n_xfer = 0;
		n_read = 0;
		n_done = 0;
		@(posedge clk_sys);
		#1;
		trig_mode = m;
		trig_src = s;
		frames = fr;
		dly1 = m ? 24'h1d4c : 24'h5;
		@(posedge clk_sys);
		#1 start = 1'b1;
		@(posedge clk_sys);
		#1 start = 1'b0;
	endtask

	task automatic wait_done(input int lim);
		for (int i = 0; i < lim && n_done == 0; i++) @(posedge clk_sys);
		#1;
		chk("done pulses", 32'h1, n_done);
		chk("busy at end", 32'h0, {31'h0, busy});
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (80000) @(posedge clk_sys);
		error_cnt++;
		results();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		reset = 1'b1;
		{start, abort, trig_mode, trig_pol} = 4'h0;
		trig_src = 1'b1;
		rate_hz = 20'hf4240;
		{dly1, dly2, gate_w, glow, rd} = {24'h5, 24'h5, 24'h2, 24'h4, 24'h14};
		frames = 16'h2;
		repeat (6) @(posedge clk_sys);
		#1 reset = 1'b0;
		go(1'b0, 1'b1, 16'h2);
		src.fire(1'b0, 3);
		repeat (15) @(posedge clk_sys);
		src.fire(1'b0, 3);
		wait_done(2000);
		chk("gates", 32'h2, n_gate);
		chk("xfers", 32'h1, n_xfer);
		chk("readouts", 32'h1, n_read);
		chk("frames_done", 32'h2, {16'h0, frames_done});
		chk("pair spacing", 32'h1, {31'h0, gap <= digs_pkg::PAIR_SPACE_CYC});
		span1 = span;
		$display("test one_trigger done");
		glow = 24'he;
		go(1'b0, 1'b1, 16'h2);
		src.fire(1'b0, 3);
		wait_done(2000);
		chk("afterglow span", 32'ha, span - span1);
		glow = 24'h4;
		$display("test afterglow done");
		go(1'b1, 1'b1, 16'h2);
		src.fire(1'b0, 3);
		repeat (8000) @(posedge clk_sys);
		chk("gates first shot", 32'h1, n_gate);
		chk("xfer first shot", 32'h1, n_xfer);
		chk("readout early", 32'h0, n_read);
		src.fire(1'b0, 3);
		wait_done(2000);
		chk("gates per shot", 32'h2, n_gate);
		$display("test per_shot done");
		go(1'b0, 1'b1, 16'h2);
		repeat (500) @(posedge clk_sys);
		chk("gates without ext", 32'h0, n_gate);
		#1 abort = 1'b1;
		@(posedge clk_sys);
		#1 abort = 1'b0;
		chk("busy after abort", 32'h0, {31'h0, busy});
		go(1'b1, 1'b0, 16'h4);
		wait_done(20000);
		chk("gates internal", 32'h4, n_gate);
		chk("readouts internal", 32'h2, n_read);
		chk("frames_done internal", 32'h4, {16'h0, frames_done});
		$display("test source done");
		trig_pol = 1'b1;
		gate_w = 24'h1;
		go(1'b0, 1'b1, 16'h2);
		src.drive(1'b1);
		repeat (100) @(posedge clk_sys);
		chk("gates wrong edge", 32'h0, n_gate);
		src.drive(1'b0);
		wait_done(2000);
		chk("gates falling edge", 32'h2, n_gate);
		chk("gate width", 32'h1, g_width);
		$display("test polarity done");
		for (int i = 0; i < 3; i++) begin
			#1 rate_hz = 20'hf4240 >> i;
			repeat (1200) @(posedge clk_sys);
			chk("sync period", 32'h64 << i, period);
		end
		chk("sync outputs differ", 32'h0, sync_diff);
		$display("test sync_rate done");
		results();
	end
endmodule
